/* File: sfpeu_top.v */
// Contract
// - packed integer operations never raise a numeric exception
// - detect invalid, divide-by-zero, denormal, overflow, underflow, inexact
// - exceptions reported precisely at completion, no later effects visible
// - each class has own flag and mask, loaded and read by software
// - unmasked exception with os support bit set raises simd fault
// - os support bit clear raises undefined-opcode fault instead
// - invalid flag at bit 0, invalid mask at bit 7
// - masked invalid writes the default value into the destination
// - arithmetic on signaling nan returns it quieted
// - square root of signaling nan returns it quieted
// - square root of negative nonzero returns quiet indefinite
// - max or min with any nan returns second source
// - mask compare with nan gives zeros, ones for neq and unordered
// - precision conversion of signaling nan returns it quieted
// - flag compare with nan sets unordered flags, no destination write
// - inf-inf, inf times zero, 0/0, inf/inf return quiet indefinite
// - float to int of nan, inf or out of range gives int indefinite
// - unmasked invalid leaves operands unchanged and faults
// - quiet nan alone raises no invalid, except flag compares and float to int
// - flag compare with quiet nan raises invalid
// - invalid handling ignores flush-to-zero
// - packed flags are the or of per-element conditions
// - masked exceptions give default result, set flag, no fault
`timescale 1ns/1ps
`default_nettype none
`include "sfpeu_defines.vh"

module sfpeu_top #(
  parameter LANES = 2
) (
  // clock and reset
  input wire CORE_CLK_IN,
  input wire RST_IN,
  // register bus
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [7:0] WB_ADR_IN,
  input wire [3:0] WB_SEL_IN,
  input wire [31:0] WB_DAT_IN,
  output reg [31:0] WB_DAT_OUT,
  output reg WB_ACK_OUT,
  output reg WB_ERR_OUT,
  // operation from the datapath
  input wire OP_VALID_IN,
  input wire [3:0] OP_CODE_IN,
  input wire OP_DBL_IN,
  input wire OP_PACKED_IN,
  input wire [2:0] OP_PRED_IN,
  input wire [LANES*64-1:0] OP_SRC1_IN,
  input wire [LANES*64-1:0] OP_SRC2_IN,
  input wire [LANES*64-1:0] OP_RES_IN,
  input wire [LANES-1:0] OP_OVF_IN,
  input wire [LANES-1:0] OP_UNF_IN,
  input wire [LANES-1:0] OP_INX_IN,
  input wire [LANES-1:0] OP_RANGE_IN,
  input wire [2:0] OP_FLAGS_IN,
  // completion to retirement and fault dispatch
  output reg RES_DONE_OUT,
  output reg RES_WR_OUT,
  output reg [LANES*64-1:0] RES_DATA_OUT,
  output reg RES_FLAGS_WR_OUT,
  output reg [2:0] RES_FLAGS_OUT,
  output reg SIMD_FP_FAULT_OUT,
  output reg UNDEFINED_OPCODE_FAULT_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // operand class: {neg, snan, qnan, inf, zero, denormal}
  function [5:0] fp_class;
    input [63:0] v;
    input dbl;
    reg ex1;
    reg ex0;
    reg fz;
    reg qb;
    begin
      ex1 = dbl ? (&v[62:52]) : (&v[30:23]);
      ex0 = dbl ? ~(|v[62:52]) : ~(|v[30:23]);
      fz = dbl ? ~(|v[51:0]) : ~(|v[22:0]);
      qb = dbl ? v[51] : v[22];
      fp_class = {dbl ? v[63] : v[31], ex1 & ~fz & ~qb, ex1 & qb,
                  ex1 & fz, ex0 & fz, ex0 & ~fz};
    end
  endfunction

  // set the quiet bit; single sits in the low word of a slot
  function [63:0] fp_quiet;
    input [63:0] v;
    input dbl;
    begin
      if (dbl)
        fp_quiet = v | `SFPEU_QMASK_D;
      else
        fp_quiet = {32'h0, v[31:0] | `SFPEU_QMASK_S};
    end
  endfunction

  // byte enables widened to a bit mask
  function [31:0] be_mask;
    input [3:0] sel;
    begin
      be_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  reg [31:0] csr_q;
  reg [31:0] csr_d;
  reg os_q;
  reg [31:0] last_q;

  wire [5:0] masks = csr_q[`SFPEU_MASK_LSB+5:`SFPEU_MASK_LSB];
  wire is_int = (OP_CODE_IN == `SFPEU_OP_INT);
  // ops whose datapath reports overflow, underflow and inexact
  wire is_arith = (OP_CODE_IN <= `SFPEU_OP_SQRT) |
                  (OP_CODE_IN == `SFPEU_OP_CVTP) |
                  (OP_CODE_IN == `SFPEU_OP_CVTI);
  wire is_comi = (OP_CODE_IN == `SFPEU_OP_COMI);
  wire [63:0] ind = OP_DBL_IN ? `SFPEU_IND_D : {32'h0, `SFPEU_IND_S};
  wire [63:0] ones = OP_DBL_IN ? 64'hffffffffffffffff :
                     64'h00000000ffffffff;

  wire [LANES-1:0] l_inv;
  wire [LANES-1:0] l_dz;
  wire [LANES-1:0] l_den;
  wire [LANES-1:0] l_ovf;
  wire [LANES-1:0] l_unf;
  wire [LANES-1:0] l_pe;
  wire [LANES*64-1:0] l_res;

  ////////////////////////////////////////////////////////////////////////
  // per-element detection and masked default results
  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1)
    begin : g_lane
      wire [63:0] a = OP_SRC1_IN[l*64 +: 64];
      wire [63:0] b = OP_SRC2_IN[l*64 +: 64];
      wire [63:0] r = OP_RES_IN[l*64 +: 64];
      wire [5:0] ca = fp_class(a, OP_DBL_IN);
      wire [5:0] cb = fp_class(b, OP_DBL_IN);
      wire sn = ca[4] | cb[4];
      wire nan = sn | ca[3] | cb[3];
      // scalar forms only look at element 0; integer ops never count
      wire act = OP_VALID_IN & (OP_PACKED_IN | (l == 0)) & ~is_int;
      reg inv;
      reg dz;
      reg den;
      reg ovr;
      reg bad;
      reg [63:0] val;
      wire post;

      // invalid operand pairs of the four basic ops
      always @*
      begin
        case (OP_CODE_IN)
          `SFPEU_OP_ADD: bad = ca[2] & cb[2] & (ca[5] ^ cb[5]);
          `SFPEU_OP_SUB: bad = ca[2] & cb[2] & ~(ca[5] ^ cb[5]);
          `SFPEU_OP_MUL: bad = (ca[2] & cb[1]) | (ca[1] & cb[2]);
          `SFPEU_OP_DIV: bad = (ca[1] & cb[1]) | (ca[2] & cb[2]);
          default: bad = 1'b0;
        endcase
      end

      // flush-to-zero is never consulted here
      always @*
      begin
        inv = 1'b0;
        dz = 1'b0;
        den = 1'b0;
        ovr = 1'b0;
        val = r;
        case (OP_CODE_IN)
          `SFPEU_OP_ADD, `SFPEU_OP_SUB, `SFPEU_OP_MUL, `SFPEU_OP_DIV:
          begin
            den = ~nan & (ca[0] | cb[0]);
            if (sn)
            begin
              inv = 1'b1;
              ovr = 1'b1;
              val = ca[4] ? fp_quiet(a, OP_DBL_IN) : fp_quiet(b, OP_DBL_IN);
            end
            else if (~nan & bad)
            begin
              inv = 1'b1;
              ovr = 1'b1;
              val = ind;
            end
            // finite nonzero dividend over zero
            dz = (OP_CODE_IN == `SFPEU_OP_DIV) & ~nan & cb[1] &
                 ~ca[1] & ~ca[2];
          end
          `SFPEU_OP_SQRT:
          begin
            den = cb[0];
            if (cb[4])
            begin
              inv = 1'b1;
              ovr = 1'b1;
              val = fp_quiet(b, OP_DBL_IN);
            end
            else if (cb[5] & ~cb[1] & ~cb[3])
            begin
              inv = 1'b1;
              ovr = 1'b1;
              val = ind;
            end
          end
          `SFPEU_OP_MAX, `SFPEU_OP_MIN:
          begin
            den = ~nan & (ca[0] | cb[0]);
            inv = sn;
            if (nan)
            begin
              ovr = 1'b1;
              val = b;
            end
          end
          `SFPEU_OP_CMP:
          begin
            den = ~nan & (ca[0] | cb[0]);
            inv = sn;
            if (nan)
            begin
              ovr = 1'b1;
              if ((OP_PRED_IN == `SFPEU_PRED_UNORD) |
                  (OP_PRED_IN == `SFPEU_PRED_NEQ))
                val = ones;
              else
                val = 64'h0;
            end
          end
          `SFPEU_OP_CVTP:
          begin
            den = cb[0];
            if (cb[4])
            begin
              inv = 1'b1;
              ovr = 1'b1;
              // quieted nan rebuilt in the destination format
              if (OP_DBL_IN)
                val = {32'h0, b[63], 8'hff, 1'b1, b[50:29]};
              else
                val = {b[31], 11'h7ff, 1'b1, b[21:0], 29'h0};
            end
          end
          `SFPEU_OP_CVTI:
          begin
            if (cb[4] | cb[3] | cb[2] | OP_RANGE_IN[l])
            begin
              inv = 1'b1;
              ovr = 1'b1;
              val = OP_PRED_IN[0] ? `SFPEU_INT_IND64 :
                    {32'h0, `SFPEU_INT_IND32};
            end
          end
          `SFPEU_OP_COMI:
          begin
            inv = nan;
            den = ~nan & (ca[0] | cb[0]);
          end
          default:
          begin
            inv = 1'b0;
          end
        endcase
      end

      // post-computation classes only where no invalid or divide-by-zero hit
      assign post = act & is_arith & ~inv & ~dz;
      assign l_inv[l] = act & inv;
      assign l_dz[l] = act & dz;
      assign l_den[l] = act & den;
      assign l_ovf[l] = post & OP_OVF_IN[l];
      // masked underflow counts only with inexact alongside
      assign l_unf[l] = post & OP_UNF_IN[l] &
                        (~csr_q[`SFPEU_UM_BIT] | OP_INX_IN[l]);
      assign l_pe[l] = post & OP_INX_IN[l];
      assign l_res[l*64 +: 64] = (act & ovr) ? val : r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // or-reduce across elements, bit order matches the flag field
  wire [5:0] exc = {|l_pe, |l_unf, |l_ovf, |l_dz, |l_den, |l_inv};
  wire [5:0] unm = exc & ~masks;
  wire fault = OP_VALID_IN & (|unm);

  ////////////////////////////////////////////////////////////////////////
  // completion stage: one register so nothing later can slip ahead
  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      RES_DONE_OUT <= 1'b0;
      RES_WR_OUT <= 1'b0;
      RES_DATA_OUT <= {LANES*64{1'b0}};
      RES_FLAGS_WR_OUT <= 1'b0;
      RES_FLAGS_OUT <= 3'h0;
      SIMD_FP_FAULT_OUT <= 1'b0;
      UNDEFINED_OPCODE_FAULT_OUT <= 1'b0;
    end
    else
    begin
      RES_DONE_OUT <= OP_VALID_IN;
      // a faulting op writes nothing, operands stay as they were
      RES_WR_OUT <= OP_VALID_IN & ~fault & ~is_comi;
      RES_DATA_OUT <= l_res;
      RES_FLAGS_WR_OUT <= OP_VALID_IN & ~fault & is_comi;
      RES_FLAGS_OUT <= l_inv[0] ? `SFPEU_UNORD_FLAGS : OP_FLAGS_IN;
      SIMD_FP_FAULT_OUT <= fault & os_q;
      UNDEFINED_OPCODE_FAULT_OUT <= fault & ~os_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode; writes land on the edge where ack is seen
  wire req = WB_CYC_IN & WB_STB_IN;
  wire hit = (WB_ADR_IN == `SFPEU_ADR_CSR) |
             (WB_ADR_IN == `SFPEU_ADR_SCR4) |
             (WB_ADR_IN == `SFPEU_ADR_LAST);
  wire wr = req & WB_WE_IN & WB_ACK_OUT;
  wire [31:0] bm = be_mask(WB_SEL_IN);
  wire [31:0] cm = bm & `SFPEU_CSR_WMASK;

  // flags and masks; a hardware set wins over a same-cycle clear
  always @*
  begin
    csr_d = csr_q;
    if (wr & (WB_ADR_IN == `SFPEU_ADR_CSR))
      csr_d = (csr_q & ~cm) | (WB_DAT_IN & cm);
    if (OP_VALID_IN)
      csr_d[`SFPEU_FLAG_LSB+5:`SFPEU_FLAG_LSB] =
        csr_d[`SFPEU_FLAG_LSB+5:`SFPEU_FLAG_LSB] | exc;
  end

  // control/status register, invalid flag bit 0 and mask bit 7
  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      csr_q <= `SFPEU_CSR_RST;
    else
      csr_q <= csr_d;
  end

  // os support bit and last fault record
  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      os_q <= 1'b0;
      last_q <= 32'h0;
    end
    else
    begin
      if (wr & (WB_ADR_IN == `SFPEU_ADR_SCR4) & bm[`SFPEU_OSFS_BIT])
        os_q <= WB_DAT_IN[`SFPEU_OSFS_BIT];
      if (fault)
        last_q <= {18'h0, unm, 6'h0, ~os_q, os_q};
    end
  end

  // classic single cycle: ack one cycle after the request, then drop
  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      WB_ACK_OUT <= 1'b0;
      WB_ERR_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0;
    end
    else
    begin
      WB_ACK_OUT <= req & hit & ~WB_ACK_OUT & ~WB_ERR_OUT;
      WB_ERR_OUT <= req & ~hit & ~WB_ACK_OUT & ~WB_ERR_OUT;
      // unmapped and reserved bits read as zero
      if (WB_ADR_IN == `SFPEU_ADR_CSR)
        WB_DAT_OUT <= csr_q & `SFPEU_CSR_WMASK;
      else if (WB_ADR_IN == `SFPEU_ADR_SCR4)
        WB_DAT_OUT <= {21'h0, os_q, 10'h0};
      else if (WB_ADR_IN == `SFPEU_ADR_LAST)
        WB_DAT_OUT <= last_q;
      else
        WB_DAT_OUT <= 32'h0;
    end
  end

endmodule // sfpeu_top

`default_nettype wire

/* File: sfpeu_defines.vh */
`ifndef SFPEU_DEFINES_VH
`define SFPEU_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses on the bus)
`define SFPEU_ADR_CSR 8'h00
`define SFPEU_ADR_SCR4 8'h04
`define SFPEU_ADR_LAST 8'h08

////////////////////////////////////////////////////////////////////////
// control/status layout
`define SFPEU_CSR_RST 32'h00001f80
`define SFPEU_CSR_WMASK 32'h0000ffff
`define SFPEU_FLAG_LSB 0
`define SFPEU_MASK_LSB 7
`define SFPEU_INV_FLAG_BIT 0
`define SFPEU_UM_BIT 11
`define SFPEU_OSFS_BIT 10

////////////////////////////////////////////////////////////////////////
// operation codes from the datapath
`define SFPEU_OP_ADD 4'h0
`define SFPEU_OP_SUB 4'h1
`define SFPEU_OP_MUL 4'h2
`define SFPEU_OP_DIV 4'h3
`define SFPEU_OP_SQRT 4'h4
`define SFPEU_OP_MAX 4'h5
`define SFPEU_OP_MIN 4'h6
`define SFPEU_OP_CMP 4'h7
`define SFPEU_OP_CVTP 4'h8
`define SFPEU_OP_CVTI 4'h9
`define SFPEU_OP_COMI 4'ha
`define SFPEU_OP_INT 4'hb

////////////////////////////////////////////////////////////////////////
// compare predicates that answer true on unordered
`define SFPEU_PRED_UNORD 3'h3
`define SFPEU_PRED_NEQ 3'h4

////////////////////////////////////////////////////////////////////////
// default values
`define SFPEU_QMASK_S 32'h00400000
`define SFPEU_QMASK_D 64'h0008000000000000
`define SFPEU_IND_S 32'hffc00000
`define SFPEU_IND_D 64'hfff8000000000000
`define SFPEU_INT_IND32 32'h80000000
`define SFPEU_INT_IND64 64'h8000000000000000
`define SFPEU_UNORD_FLAGS 3'h7

`endif

/* File: sfpeu_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfpeu_defines.vh"
module sfpeu_top_sva #(
  parameter LANES = 2
) (
  // clock, reset, bus
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  input wire logic WB_ERR_OUT,
  // op side
  input wire logic OP_VALID_IN,
  input wire logic [3:0] OP_CODE_IN,
  input wire logic OP_DBL_IN,
  input wire logic OP_PACKED_IN,
  input wire logic [2:0] OP_PRED_IN,
  input wire logic [LANES*64-1:0] OP_SRC1_IN,
  input wire logic [LANES*64-1:0] OP_SRC2_IN,
  // completion side
  input wire logic RES_DONE_OUT,
  input wire logic RES_WR_OUT,
  input wire logic [LANES*64-1:0] RES_DATA_OUT,
  input wire logic RES_FLAGS_WR_OUT,
  input wire logic SIMD_FP_FAULT_OUT,
  input wire logic UNDEFINED_OPCODE_FAULT_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////
  // scalar single op; only lane 0 low word is judged
  wire logic sc = OP_VALID_IN && !OP_DBL_IN && !OP_PACKED_IN;
  wire logic nan1 = &OP_SRC1_IN[30:23] && |OP_SRC1_IN[22:0];
  wire logic [31:0] b = OP_SRC2_IN[31:0];
  wire logic flt = SIMD_FP_FAULT_OUT || UNDEFINED_OPCODE_FAULT_OUT;
  ////////////////////////////////////////
  done_next_a:
    assert property (RES_DONE_OUT == $past(OP_VALID_IN))
    else $error("done out of step");
  int_calm_a:
    assert property (OP_VALID_IN && OP_CODE_IN == `SFPEU_OP_INT |=> !flt)
    else $error("fault on integer op");
  fault_nowr_a:
    assert property (flt |-> RES_DONE_OUT && !RES_WR_OUT && !RES_FLAGS_WR_OUT)
    else $error("fault with a write");
  comi_nowr_a:
    assert property (OP_VALID_IN && OP_CODE_IN == `SFPEU_OP_COMI
      |=> !RES_WR_OUT) else $error("flag compare wrote data");
  root_ind_a:
    assert property (sc && OP_CODE_IN == `SFPEU_OP_SQRT && b[31] && |b[30:0]
      && !(&b[30:23]) |=> !RES_WR_OUT || RES_DATA_OUT[31:0] == `SFPEU_IND_S)
    else $error("negative root result");
  cmp_ones_a:
    assert property (sc && OP_CODE_IN == `SFPEU_OP_CMP && nan1 &&
      (OP_PRED_IN == `SFPEU_PRED_UNORD || OP_PRED_IN == `SFPEU_PRED_NEQ)
      |=> !RES_WR_OUT || &RES_DATA_OUT[31:0]) else $error("compare mask");
  max_src2_a:
    assert property (sc && OP_CODE_IN inside {`SFPEU_OP_MAX, `SFPEU_OP_MIN}
      && nan1 |=> !RES_WR_OUT || RES_DATA_OUT[31:0] == $past(b))
    else $error("max or min result");
  bus_ack_a:
    assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT
      |=> (WB_ACK_OUT ^ WB_ERR_OUT) ##1 !WB_ACK_OUT)
    else $error("bus answer timing");
  // main paths seen
  cover property (SIMD_FP_FAULT_OUT);
  cover property (UNDEFINED_OPCODE_FAULT_OUT);
  cover property (RES_FLAGS_WR_OUT);
  cover property (WB_ERR_OUT);
endmodule // sfpeu_top_sva
bind sfpeu_top sfpeu_top_sva #(.LANES(LANES)) u_sva (
  .CORE_CLK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN, .WB_ACK_OUT, .WB_ERR_OUT,
  .OP_VALID_IN, .OP_CODE_IN, .OP_DBL_IN, .OP_PACKED_IN, .OP_PRED_IN,
  .OP_SRC1_IN, .OP_SRC2_IN, .RES_DONE_OUT, .RES_WR_OUT, .RES_DATA_OUT,
  .RES_FLAGS_WR_OUT, .SIMD_FP_FAULT_OUT, .UNDEFINED_OPCODE_FAULT_OUT
);
`default_nettype wire

/* File: sfpeu_dpath_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfpeu_dpath_model (
  // clock
  input wire logic clk_in,
  // finished op toward the unit
  output logic op_valid_out = 1'b0,
  output logic [3:0] op_code_out = 4'h0,
  output logic [2:0] op_pred_out = 3'h0,
  output logic op_packed_out = 1'b0,
  output logic [127:0] op_src1_out = 128'h0,
  output logic [127:0] op_src2_out = 128'h0,
  output logic [127:0] op_res_out = 128'h0,
  output logic [1:0] op_inx_out = 2'h0
);
  ////////////////////////////////////////
  // one op per call, held one cycle; gap models a slow datapath
  task automatic issue(input logic [3:0] c, input logic [2:0] p,
    input logic k, input logic [127:0] a, input logic [127:0] b,
    input logic [127:0] r, input logic [1:0] x, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    op_valid_out <= 1'b1;
    op_code_out <= c;
    op_pred_out <= p;
    op_packed_out <= k;
    op_src1_out <= a;
    op_src2_out <= b;
    op_res_out <= r;
    op_inx_out <= x;
    @(posedge clk_in);
    op_valid_out <= 1'b0;
    // stale operands scrambled so nothing leans on them
    op_src1_out <= ~a;
    op_src2_out <= ~b;
  endtask
endmodule // sfpeu_dpath_model
`default_nettype wire

/* File: simd_fp_exception_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfpeu_defines.vh"
module simd_fp_exception_unit_test;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ov, pk, done, wr, fwr, xf, ud, be, ack, err;
  logic [1:0] ix, ovf = 2'b00, unf = 2'b00;
  logic dbl = 1'b0;
  logic [2:0] pr, fl;
  logic [3:0] oc, got, i, sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, seed = 32'h2c23, rdat, rv;
  logic [127:0] s1, s2, rs, dat, qn = {96'h0, 32'h7fc00000};
  int miscompares = 0, tests_run = 0;
  // 250 MHz core clock
  always #2 clk = ~clk;
  sfpeu_dpath_model u_dp (
    .clk_in(clk), .op_valid_out(ov), .op_code_out(oc), .op_pred_out(pr),
    .op_packed_out(pk), .op_src1_out(s1), .op_src2_out(s2),
    .op_res_out(rs), .op_inx_out(ix)
  );
  sfpeu_top #(.LANES(2)) DUT (
    .CORE_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .WB_ERR_OUT(err),
    .OP_VALID_IN(ov), .OP_CODE_IN(oc), .OP_DBL_IN(dbl),
    .OP_PACKED_IN(pk), .OP_PRED_IN(pr), .OP_SRC1_IN(s1), .OP_SRC2_IN(s2),
    .OP_RES_IN(rs), .OP_OVF_IN(ovf), .OP_UNF_IN(unf), .OP_INX_IN(ix),
    .OP_RANGE_IN(2'b00), .OP_FLAGS_IN(rs[2:0]), .RES_DONE_OUT(done),
    .RES_WR_OUT(wr), .RES_DATA_OUT(dat), .RES_FLAGS_WR_OUT(fwr),
    .RES_FLAGS_OUT(fl), .SIMD_FP_FAULT_OUT(xf),
    .UNDEFINED_OPCODE_FAULT_OUT(ud)
  );
  ////////////////////////////////////////
  // xorshift step; fixed start keeps runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // signaling nan with a random payload
  function automatic logic [31:0] sn(input logic [31:0] v);
    return {v[31], 9'h1fe, v[21:1], 1'b1};
  endfunction
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t: saw %h, wanted %h", $time, g, e);
    end
  endtask
  // single bus cycle, held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    for (n = 0; n < 8 && ack !== 1'b1 && err !== 1'b1; n++)
      @(posedge clk);
    be = err;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 8)
    begin
      miscompares++;
      print_verdict;
    end
  endtask
  // one op, then outputs taken mid-cycle while done stands
  task automatic op(input logic [3:0] c, input logic [2:0] p,
    input logic k, input logic [127:0] a, input logic [127:0] b,
    input logic [127:0] r, input logic [1:0] x);
    int n;
    u_dp.issue(c, p, k, a, b, r, x, tests_run % 2);
    for (n = 0; n < 4 && done !== 1'b1; n++)
      @(negedge clk);
    got = {xf, ud, wr, fwr};
    if (n == 4)
    begin
      miscompares++;
      print_verdict;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(0, `SFPEU_ADR_CSR, 0, rv);
    chk(rv, 32'h1f80);
    wb(0, `SFPEU_ADR_SCR4, 0, rv);
    chk(rv, 0);
    wb(0, 8'h0c, 0, rv);
    chk({be, rv}, {1'b1, 32'h0});
    $display("reset test over");
    // masked signaling nan through add, sub, mul, div, root
    for (i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      op(i, 0, 0, {96'h0, sn(seed)}, {96'h0, sn(seed)}, 0, 0);
      chk(dat[63:0], {32'h0, sn(seed) | `SFPEU_QMASK_S});
      chk(got, 4'b0010);
    end
    op(`SFPEU_OP_SQRT, 0, 0, 0, {96'h0, 32'hbf800000}, 0, 0);
    chk(dat[63:0], {32'h0, `SFPEU_IND_S});
    for (i = 5; i < 7; i++)
    begin
      seed = xs(seed);
      op(i, 0, 0, qn, {96'h0, seed}, 0, 0);
      chk(dat[63:0], {32'h0, seed});
    end
    for (i = 0; i < 8; i++)
    begin
      op(`SFPEU_OP_CMP, i[2:0], 0, qn, 0, 0, 0);
      chk(dat[63:0], (i == 3 || i == 4) ? 64'hffffffff : 64'h0);
    end
    op(`SFPEU_OP_COMI, 0, 0, qn, 0, 0, 0);
    chk({got, fl}, 7'b0001111);
    // to-int, precision convert, divide-by-zero and denormal, single
    op(`SFPEU_OP_CVTI, 3'h1, 0, 0, qn, 0, 0);
    chk(dat[63:0], `SFPEU_INT_IND64);
    op(`SFPEU_OP_CVTI, 3'h0, 0, 0, {96'h0, 32'h7f800000}, 0, 0);
    chk(dat[63:0], {32'h0, `SFPEU_INT_IND32});
    seed = xs(seed);
    rv = sn(seed);
    op(`SFPEU_OP_CVTP, 0, 0, 0, {96'h0, rv}, 0, 0);
    chk(dat[63:0], {rv[31], 11'h7ff, 1'b1, rv[21:0], 29'h0});
    op(`SFPEU_OP_DIV, 0, 0, {96'h0, 32'h3f800000}, 0, 0, 0);
    chk(got, 4'b0010);
    op(`SFPEU_OP_ADD, 0, 0, {96'h0, 32'h1}, 0, 0, 0);
    chk(got, 4'b0010);
    // double format: root and narrowing of a signaling nan
    @(posedge clk);
    dbl <= 1'b1;
    op(`SFPEU_OP_SQRT, 0, 0, 0, {64'h0, 32'h7ff00000, seed | 32'h1}, 0, 0);
    chk(dat[63:0], {32'h7ff80000, seed | 32'h1});
    op(`SFPEU_OP_CVTP, 0, 0, 0, {64'h0, 32'h7ff00000, seed | 32'h1}, 0, 0);
    chk(dat[63:0], {33'h0, 8'hff, 1'b1, 19'h0, seed[31:29]});
    @(posedge clk);
    dbl <= 1'b0;
    wb(0, `SFPEU_ADR_CSR, 0, rv);
    chk(rv, 32'h1f87);
    $display("masked test over");
    // clear by software, integer ops stay silent, one lane inexact
    wb(1, `SFPEU_ADR_CSR, 32'h1f80, rv);
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      op(`SFPEU_OP_INT, 0, 1, {4{seed}}, {4{~seed}}, {4{seed}}, seed[1:0]);
      chk(got, 4'b0010);
    end
    // lane 0 overflows, lane 1 underflows with inexact
    @(posedge clk);
    ovf <= 2'b01;
    unf <= 2'b10;
    op(`SFPEU_OP_ADD, 0, 1, {4{32'h3f800000}}, {4{32'h3f800000}}, 0, 2'b10);
    @(posedge clk);
    ovf <= 2'b00;
    unf <= 2'b00;
    wb(0, `SFPEU_ADR_CSR, 0, rv);
    chk(rv, 32'h1fb8);
    $display("packed test over");
    // unmasked invalid, first without then with os support
    wb(1, `SFPEU_ADR_CSR, 32'h1f00, rv);
    op(`SFPEU_OP_COMI, 0, 0, qn, 0, 0, 0);
    chk(got, 4'b0100);
    wb(1, `SFPEU_ADR_SCR4, 32'h400, rv);
    wb(1, `SFPEU_ADR_CSR, 32'h9f00, rv);
    op(`SFPEU_OP_COMI, 0, 0, qn, 0, 0, 0);
    chk(got, 4'b1000);
    op(`SFPEU_OP_ADD, 0, 0, {96'h0, sn(seed)}, 0, 0, 0);
    chk(got, 4'b1000);
    op(`SFPEU_OP_MAX, 0, 0, qn, {96'h0, 32'h3f800000}, 0, 0);
    chk({got, dat[31:0]}, {4'b0010, 32'h3f800000});
    wb(0, `SFPEU_ADR_CSR, 0, rv);
    chk(rv, 32'h9f01);
    // last fault record: the faulting add, simd fault, invalid class
    wb(0, `SFPEU_ADR_LAST, 0, rv);
    chk(rv, 32'h101);
    $display("unmasked test over");
    print_verdict;
  end
endmodule // simd_fp_exception_unit_test
`default_nettype wire
